/* File: shared/rxff_consts.svh */
/*
 * Constants of the receive frame FIFO controller: buffer sizing, status word
 * field positions, frame length limits, register offsets and reset values.
 * Assumes inclusion by bare name from the package and the controller module.
 */
`ifndef RXFF_CONSTS_SVH
`define RXFF_CONSTS_SVH

// ****************************************************************
// Buffer sizing
// ****************************************************************
`define RXFF_SRAM_KB 28
`define RXFF_RX_KB 20
`define RXFF_TX_KB (`RXFF_SRAM_KB - `RXFF_RX_KB)
`define RXFF_RX_WORDS (`RXFF_RX_KB * 1024 / 4)
`define RXFF_BLOCK_BYTES 512
`define RXFF_BLOCK_WORDS (`RXFF_BLOCK_BYTES / 4)

// ****************************************************************
// Frame length limits in bytes
// ****************************************************************
`define RXFF_RUNT_BYTES 64
`define RXFF_MAX_BYTES 1518

// ****************************************************************
// Status word field positions
// ****************************************************************
`define RXFF_ST_FILTER_FAIL 30
`define RXFF_ST_LEN_HI 29
`define RXFF_ST_LEN_LO 16
`define RXFF_ST_ERROR_SUMMARY 15
`define RXFF_ST_BROADCAST 13
`define RXFF_ST_SIZE_MISMATCH 12
`define RXFF_ST_RUNT 11
`define RXFF_ST_MULTICAST 10
`define RXFF_ST_TOO_LONG 7
`define RXFF_ST_LATE_COLL 6
`define RXFF_ST_CRC 1

// ****************************************************************
// Register offsets, control fields and reset values
// ****************************************************************
`define RXFF_REG_CFG 8'h00
`define RXFF_REG_OVF_COUNT 8'h04
`define RXFF_REG_WR_PTR 8'h08
`define RXFF_REG_RD_PTR 8'h0c
`define RXFF_REG_VISIBLE 8'h10
`define RXFF_CFG_OFFSET_LO 0
`define RXFF_CFG_DISCARD 2
`define RXFF_CFG_PASS_BAD 3
`define RXFF_CFG_FLUSH 4
`define RXFF_CFG_RST 4'h0
`define RXFF_WR_HEAD_RST 0
`define RXFF_WR_PTR_RST 1
`define RXFF_RD_PTR_RST 0

`endif

/* File: shared/rxff_pkg.sv */
/*
 * Types of the receive frame FIFO controller: receive flags from the MAC
 * transfer interface, control settings and write-side states.
 * Assumes the constants header sits beside it on the include path.
 */
package rxff_pkg;
    `include "rxff_consts.svh"

    // Per-frame flags delivered with the final status transfer
    typedef struct packed {
        logic filter_fail;
        logic broadcast;
        logic multicast;
        logic size_type_mismatch;
        logic late_collision;
        logic crc_error;
        logic rx_error;
    } rxff_mac_flags_type;

    // Software settings
    typedef struct packed {
        logic pass_bad_frames;
        logic discard_errored_frames;
        logic [1:0] rx_data_offset;
    } rxff_cfg_type;

    typedef enum logic [3:0] {
        RXFF_IDLE = 4'b0001,
        RXFF_RECV = 4'b0010,
        RXFF_WAIT_STATUS = 4'b0100,
        RXFF_DISCARD = 4'b1000
    } rxff_state_type;
endpackage : rxff_pkg

/* File: core/rxff_mem.sv */
/*
 * Receive buffer memory: one write port, one read port, registered read data.
 * Assumes a single clock; contents are undefined after reset.
 */
`timescale 1ns/100ps
module rxff_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 5120,
    parameter int AW = 13
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] store [DEPTH];

    // Array write; no reset so it maps onto SRAM
    always_ff @(posedge clock) begin
        if (we) begin
            store[waddr] <= wdata;
        end
    end

    // Read data register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else if (re) begin
            rdata <= store[raddr];
        end
    end
endmodule : rxff_mem

/* File: core/rxff_ctrl.sv */
/*
 * Receive frame FIFO controller: packs MAC bytes into words, stores frames
 * behind a head pointer, commits or rewinds them, and feeds the USB transmit
 * engine. Assumes all inputs come from logic on the same clock.
 */
// What this block does
// R1 - Receive buffer takes 20 kB of the 28 kB memory.
// R2 - Stored data is offered to USB in 512-byte blocks.
// R3 - Data goes through write pointer; status lands at head pointer slot.
// R4 - MAC sends frame bytes first, status transfer last.
// R5 - Zero to three padding bytes precede each frame, set by data offset.
// R6 - Frame is hidden from USB until its status word is written.
// R7 - With discard enabled, frames with CRC, collision, long or runt errors drop.
// R8 - FIFO full during a frame is overflow and drops that frame.
// R9 - Every overflow increments the overflow counter.
// R10 - Write-side drop loads write pointer from write head pointer.
// R11 - USB rewind loads read pointer from read head pointer.
// R12 - After overflow, rest of frame is ignored until next frame starts.
// R13 - Status bit 30 marks filter failure; bits 31, 14, 9:8 reserved zero.
// R14 - Status bits 29:16 hold frame size in bytes.
// R15 - Status bit 15 is OR of bits 11, 7, 6 and 1.
// R16 - Status bit 13 broadcast, bit 10 multicast.
// R17 - Status bit 12 flags length/type field mismatch.
// R18 - Status bit 11 flags frames under 64 bytes; passed only with pass-bad.
// R19 - Status bit 7 flags frames over 1518 bytes; never truncated.
// R20 - Status bit 6 flags late collision.
// R21 - Status bit 1 flags CRC error or receive error.
// R22 - Flush returns read and write pointers to reset values.
// R23 - Pointers wrap modulo buffer size; commit moves head past the frame.
// R24 - Full when the slot after the next word's address is the read head pointer slot.
`timescale 1ns/100ps
`include "rxff_consts.svh"
module rxff_ctrl
    import rxff_pkg::*;
#(
    parameter int DEPTH = `RXFF_RX_WORDS, // R1
    parameter int AW = 13,
    parameter int BLOCK_WORDS = `RXFF_BLOCK_WORDS
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic mac_byte_valid,
    input wire logic [7:0] mac_byte,
    input wire logic mac_byte_first,
    input wire logic mac_byte_last,
    input wire logic mac_status_valid,
    input wire rxff_mac_flags_type mac_flags,
    input wire logic usb_rd_req,
    input wire logic usb_release,
    input wire logic usb_rewind,
    output logic usb_rd_valid,
    output logic [31:0] usb_rd_data,
    output logic usb_frame_avail,
    output logic usb_block_ready
);
    // ****************************************************************
    // Functions
    // ****************************************************************
    // Pointer increment with wrap at the buffer end
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1; // R23
    endfunction : ptr_inc

    // Words between two pointers, modulo the buffer size
    function automatic logic [AW-1:0] ptr_span(input logic [AW-1:0] hi, input logic [AW-1:0] lo);
        ptr_span = (hi >= lo) ? AW'(hi - lo) : AW'(hi + AW'(DEPTH) - lo); // R23
    endfunction : ptr_span

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    rxff_cfg_type cfg;
    rxff_state_type state;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] wr_head;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] rd_head;
    logic [31:0] ovf_count;
    logic [31:0] acc;
    logic [1:0] lane;
    logic [13:0] byte_count;

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire flush_go = reg_wr && (reg_addr == `RXFF_REG_CFG) && reg_wdata[`RXFF_CFG_FLUSH];
    wire [AW-1:0] visible = ptr_span(wr_head, rd_ptr);
    wire read_ok = usb_rd_req && (visible != '0) && !usb_rewind && !flush_go;
    wire start_byte = mac_byte_valid && mac_byte_first;
    wire [AW-1:0] data_addr = start_byte ? ptr_inc(wr_head) : wr_ptr; // R3
    wire full = (ptr_inc(data_addr) == rd_head); // R24
    wire [1:0] byte_lane = start_byte ? cfg.rx_data_offset : lane; // R5
    wire word_done = mac_byte_valid && ((byte_lane == 2'd3) || mac_byte_last);
    wire storing = (state == RXFF_RECV) || start_byte;
    wire data_we = storing && word_done && !full && !flush_go;
    wire overflow = storing && word_done && full && !flush_go; // R8
    wire [31:0] acc_base = (start_byte || byte_lane == 2'd0) ? 32'h0 : acc;
    wire [31:0] next_acc = acc_base | (32'(mac_byte) << {byte_lane, 3'b000});
    wire [13:0] next_count = start_byte ? 14'h1 : ((byte_count == 14'h3fff) ? byte_count : byte_count + 14'h1);
    wire status_in = mac_status_valid && (state == RXFF_WAIT_STATUS) && !flush_go; // R4

    // Status word assembly from own length count and MAC flags
    wire is_runt = byte_count < 14'(`RXFF_RUNT_BYTES); // R18
    wire too_long = byte_count > 14'(`RXFF_MAX_BYTES); // R19
    wire crc_bit = mac_flags.crc_error || mac_flags.rx_error; // R21
    wire err_sum = is_runt || too_long || mac_flags.late_collision || crc_bit; // R15
    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0; // R13
        status_word[`RXFF_ST_FILTER_FAIL] = mac_flags.filter_fail; // R13
        status_word[`RXFF_ST_LEN_HI:`RXFF_ST_LEN_LO] = byte_count; // R14
        status_word[`RXFF_ST_ERROR_SUMMARY] = err_sum; // R15
        status_word[`RXFF_ST_BROADCAST] = mac_flags.broadcast; // R16
        status_word[`RXFF_ST_SIZE_MISMATCH] = mac_flags.size_type_mismatch; // R17
        status_word[`RXFF_ST_RUNT] = is_runt; // R18
        status_word[`RXFF_ST_MULTICAST] = mac_flags.multicast; // R16
        status_word[`RXFF_ST_TOO_LONG] = too_long; // R19
        status_word[`RXFF_ST_LATE_COLL] = mac_flags.late_collision; // R20
        status_word[`RXFF_ST_CRC] = crc_bit; // R21
    end

    // Keep or drop; runts need pass-bad even when discard is off
    wire drop_err = (cfg.discard_errored_frames && err_sum) || (is_runt && !cfg.pass_bad_frames); // R7 R18
    wire commit = status_in && !drop_err; // R6
    wire drop = (status_in && drop_err) || overflow;

    // Single memory write port: status slot or data slot
    wire mem_we = data_we || commit;
    wire [AW-1:0] mem_waddr = commit ? wr_head : data_addr; // R3
    wire [31:0] mem_wdata = commit ? status_word : next_acc;

    // ****************************************************************
    // Write-side state machine
    // ****************************************************************
    rxff_state_type next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            RXFF_IDLE, RXFF_WAIT_STATUS, RXFF_DISCARD: begin
                // A new frame restarts, which ends any discard, unless overflow or flush below overrides it
                if (start_byte) begin
                    next_state = RXFF_RECV; // R12
                end else if (status_in) begin
                    next_state = RXFF_IDLE;
                end
            end
            RXFF_RECV: begin
                if (mac_byte_valid && mac_byte_last) begin
                    next_state = RXFF_WAIT_STATUS;
                end
            end
        endcase
        if (overflow) begin
            next_state = RXFF_DISCARD; // R12
        end
        if (flush_go) begin
            next_state = RXFF_IDLE;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= RXFF_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Byte packing and length count
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            acc <= '0;
            lane <= '0;
            byte_count <= '0;
        end else if (mac_byte_valid) begin
            acc <= next_acc;
            lane <= byte_lane + 2'd1;
            byte_count <= next_count; // R19
        end
    end

    // Write pointers; a frame always starts one slot past the head
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wr_ptr <= AW'(`RXFF_WR_PTR_RST);
            wr_head <= AW'(`RXFF_WR_HEAD_RST);
        end else if (flush_go) begin
            wr_ptr <= AW'(`RXFF_WR_PTR_RST); // R22
            wr_head <= AW'(`RXFF_WR_HEAD_RST); // R22
        end else if (drop) begin
            wr_ptr <= wr_head; // R10
        end else if (commit) begin
            wr_head <= wr_ptr; // R23
            wr_ptr <= ptr_inc(wr_ptr); // R23
        end else if (start_byte && !data_we) begin
            wr_ptr <= ptr_inc(wr_head); // R3
        end else if (start_byte) begin
            wr_ptr <= ptr_inc(ptr_inc(wr_head)); // R3
        end else if (data_we) begin
            wr_ptr <= ptr_inc(wr_ptr); // R3
        end
    end

    // Overflow counter, wraps on rollover
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ovf_count <= '0;
        end else if (overflow) begin
            ovf_count <= ovf_count + 32'h1; // R9
        end
    end

    // ****************************************************************
    // Read side
    // ****************************************************************
    // Rewind beats release and read advance; release and read advance act together in one cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_ptr <= AW'(`RXFF_RD_PTR_RST);
            rd_head <= AW'(`RXFF_RD_PTR_RST);
        end else if (flush_go) begin
            rd_ptr <= AW'(`RXFF_RD_PTR_RST); // R22
            rd_head <= AW'(`RXFF_RD_PTR_RST); // R22
        end else if (usb_rewind) begin
            rd_ptr <= rd_head; // R11
        end else begin
            if (read_ok) begin
                rd_ptr <= ptr_inc(rd_ptr);
            end
            if (usb_release) begin
                rd_head <= read_ok ? ptr_inc(rd_ptr) : rd_ptr;
            end
        end
    end

    // Availability flags seen by the USB engine
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            usb_rd_valid <= 1'b0;
            usb_frame_avail <= 1'b0;
            usb_block_ready <= 1'b0;
        end else begin
            usb_rd_valid <= read_ok;
            usb_frame_avail <= (visible != '0); // R6
            usb_block_ready <= (visible >= AW'(BLOCK_WORDS)); // R2
        end
    end

    rxff_mem #(
        .WIDTH(32),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_mem (
        .clock(clock),
        .nrst(nrst),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .re(read_ok),
        .raddr(rd_ptr),
        .rdata(usb_rd_data)
    );

    // ****************************************************************
    // Register port
    // ****************************************************************
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg <= `RXFF_CFG_RST;
        end else if (reg_wr && (reg_addr == `RXFF_REG_CFG)) begin
            cfg <= reg_wdata[`RXFF_CFG_PASS_BAD:`RXFF_CFG_OFFSET_LO];
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            `RXFF_REG_CFG: rd_mux = 32'(cfg);
            `RXFF_REG_OVF_COUNT: rd_mux = ovf_count;
            `RXFF_REG_WR_PTR: rd_mux = (32'(wr_head) << 16) | 32'(wr_ptr);
            `RXFF_REG_RD_PTR: rd_mux = (32'(rd_head) << 16) | 32'(rd_ptr);
            `RXFF_REG_VISIBLE: rd_mux = 32'(visible);
            default: rd_mux = 32'h0;
        endcase
    end

    // Read data stands for the one cycle after the strobe only
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence seq_overflow;
        overflow ##1 (state == RXFF_DISCARD);
    endsequence

    sequence seq_no_store;
        !data_we [*2];
    endsequence

    a_overflow_discard: assert property (seq_overflow |-> seq_no_store or ##[0:1] start_byte) // R12
        else $error("data stored after overflow");
    a_overflow_count: assert property (overflow |=> ovf_count == $past(ovf_count) + 32'h1) // R9
        else $error("overflow not counted");
    a_drop_rewind: assert property (drop && !flush_go |=> wr_ptr == $past(wr_head)) // R10
        else $error("write pointer not rewound to head");
    a_read_rewind: assert property (usb_rewind && !flush_go |=> rd_ptr == $past(rd_head)) // R11
        else $error("read pointer not rewound to head");
    a_flush_pointers: assert property (flush_go |=> wr_ptr == AW'(1) && wr_head == '0 && rd_ptr == '0) // R22
        else $error("flush left pointers set");
    a_head_on_commit: assert property ($changed(wr_head) |-> $past(commit) || $past(flush_go)) // R6
        else $error("frame made visible without commit");
    a_error_summary: assert property (commit |-> status_word[15] ==
        (status_word[11] | status_word[7] | status_word[6] | status_word[1])) // R15
        else $error("error summary wrong");
    a_no_overwrite: assert property (data_we |-> data_addr != rd_head) // R24
        else $error("write over unreleased data");
    a_read_latency: assert property (read_ok |=> usb_rd_valid ##1 !usb_rd_valid || $past(read_ok)) // R2
        else $error("read data timing wrong");
    a_pad_offset: assert property (start_byte && data_we |-> cfg.rx_data_offset == 2'd3 || mac_byte_last) // R5
        else $error("padding lane wrong");
endmodule : rxff_ctrl

/* File: dv/rxff_mac_model.sv */
/*
 * Behavioural MAC transfer interface: sends one frame of counting bytes,
 * then one status transfer with the given flags.
 * Assumes the bench raises start for one cycle only while busy is low.
 */
`timescale 1ns/100ps
module rxff_mac_model
    import rxff_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic start,
    input wire logic [15:0] len_in,
    input wire logic [7:0] seed_in,
    input wire rxff_mac_flags_type flags_in,
    output logic mac_byte_valid,
    output logic [7:0] mac_byte,
    output logic mac_byte_first,
    output logic mac_byte_last,
    output logic mac_status_valid,
    output rxff_mac_flags_type mac_flags,
    output logic busy
);
    // ****************************************************************
    // Frame sender
    // ****************************************************************
    logic [15:0] idx;

    // Idle byte and flag lines toggle so that a stale value is never mistaken for data
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            {mac_byte_valid, mac_byte_first, mac_byte_last, mac_status_valid, busy} <= 5'h0;
            mac_byte <= 8'h00;
            mac_flags <= '0;
            idx <= 16'h0;
        end else begin
            mac_status_valid <= 1'b0;
            mac_byte_valid <= 1'b0;
            mac_byte_first <= 1'b0;
            mac_byte_last <= 1'b0;
            mac_byte <= ~mac_byte;
            mac_flags <= ~mac_flags;
            if (start && !busy) begin
                busy <= 1'b1;
                idx <= 16'h0;
            end else if (busy && idx < len_in) begin
                mac_byte_valid <= 1'b1;
                mac_byte_first <= (idx == 16'h0);
                mac_byte_last <= (idx == len_in - 16'h1);
                mac_byte <= seed_in + idx[7:0];
                idx <= idx + 16'h1;
            end else if (busy && idx == len_in) begin
                idx <= idx + 16'h1; // Gap before status
            end else if (busy) begin
                mac_status_valid <= 1'b1;
                mac_flags <= flags_in;
                busy <= 1'b0;
            end
        end
    end
endmodule : rxff_mac_model

/* File: dv/rxff_ctrl_tb.sv */
/*
 * Self-checking bench of the receive frame FIFO controller against a queue
 * model. Assumes a reduced buffer of 512 words and 4-word blocks.
 */
`timescale 1ns/100ps
module rxff_ctrl_tb
    import rxff_pkg::*;
;
    // ****************************************************************
    // Signals, instances and helpers
    // ****************************************************************
    logic clock = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, start = 1'b0;
    logic usb_rd_req = 1'b0, usb_release = 1'b0, usb_rewind = 1'b0;
    logic [7:0] reg_addr = 8'h00, seed_in = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, usb_rd_data, lfsr = 32'hec36;
    logic [15:0] len_in = 16'h0;
    rxff_mac_flags_type flags_in = '0, mac_flags;
    logic mac_byte_valid, mac_byte_first, mac_byte_last, mac_status_valid, busy;
    logic [7:0] mac_byte;
    logic usb_rd_valid, usb_frame_avail, usb_block_ready;
    logic [31:0] exp_q[$], msk_q[$];
    int num_errors = 0, num_checks = 0, off = 0;
    bit disc = 0, passb = 0;

    always #2 clock = ~clock;

    rxff_ctrl #(.DEPTH(512), .AW(9), .BLOCK_WORDS(4)) dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mac_byte_valid(mac_byte_valid), .mac_byte(mac_byte), .mac_byte_first(mac_byte_first),
        .mac_byte_last(mac_byte_last), .mac_status_valid(mac_status_valid), .mac_flags(mac_flags),
        .usb_rd_req(usb_rd_req), .usb_release(usb_release), .usb_rewind(usb_rewind),
        .usb_rd_valid(usb_rd_valid), .usb_rd_data(usb_rd_data), .usb_frame_avail(usb_frame_avail),
        .usb_block_ready(usb_block_ready));

    rxff_mac_model mac (.clock(clock), .nrst(nrst), .start(start), .len_in(len_in), .seed_in(seed_in),
        .flags_in(flags_in), .mac_byte_valid(mac_byte_valid), .mac_byte(mac_byte),
        .mac_byte_first(mac_byte_first), .mac_byte_last(mac_byte_last),
        .mac_status_valid(mac_status_valid), .mac_flags(mac_flags), .busy(busy));

    function automatic logic [31:0] lfsr_next();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : lfsr_next

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe edge
    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        check("reg_rdata", reg_rdata, exp);
    endtask : reg_check

    task automatic set_cfg(input int o, input bit d, input bit p);
        off = o;
        disc = d;
        passb = p;
        reg_write(8'h00, {28'h0, p, d, o[1:0]});
        reg_check(8'h00, {28'h0, p, d, o[1:0]});
    endtask : set_cfg

    // Model builds status word and padded words, then the partner sends the frame
    task automatic send_frame(input int len, input rxff_mac_flags_type fl, input bit ovf);
        logic [31:0] st, w, m, r;
        int k, t;
        r = lfsr_next();
        st = 32'h0;
        st[30] = fl.filter_fail;
        st[29:16] = len;
        st[13] = fl.broadcast;
        st[10] = fl.multicast;
        st[12] = fl.size_type_mismatch;
        st[11] = (len < 64);
        st[7] = (len > 1518);
        st[6] = fl.late_collision;
        st[1] = fl.crc_error | fl.rx_error;
        st[15] = st[11] | st[7] | st[6] | st[1];
        if (!ovf && !(st[11] && !passb) && !(disc && st[15])) begin
            exp_q.push_back(st);
            msk_q.push_back(32'hffffffff);
            w = 32'h0;
            m = (32'h1 << (8 * off)) - 32'h1;
            k = off;
            for (int n = 0; n < len; n++) begin
                w[8*k+:8] = r[7:0] + n[7:0];
                m[8*k+:8] = 8'hff;
                k++;
                if (k == 4 || n == len - 1) begin
                    exp_q.push_back(w);
                    msk_q.push_back(m);
                    w = 32'h0;
                    m = 32'h0;
                    k = 0;
                end
            end
        end
        @(posedge clock);
        start <= 1'b1;
        len_in <= len[15:0];
        seed_in <= r[7:0];
        flags_in <= fl;
        @(posedge clock);
        start <= 1'b0;
        repeat (len / 2) @(posedge clock);
        check("avail_mid", usb_frame_avail, 1'b0);
        t = 0;
        while (busy && t < 3000) begin
            @(posedge clock);
            t++;
        end
        repeat (4) @(posedge clock);
        check("avail", usb_frame_avail, exp_q.size() != 0);
        check("block", usb_block_ready, exp_q.size() >= 4);
        reg_check(8'h10, exp_q.size());
    endtask : send_frame

    task automatic pulse(input bit rw);
        @(posedge clock);
        if (rw) usb_rewind <= 1'b1;
        else usb_release <= 1'b1;
        @(posedge clock);
        usb_rewind <= 1'b0;
        usb_release <= 1'b0;
    endtask : pulse

    task automatic usb_word(input int i);
        int t;
        @(posedge clock);
        usb_rd_req <= 1'b1;
        @(posedge clock);
        usb_rd_req <= 1'b0;
        t = 0;
        @(negedge clock);
        while (usb_rd_valid !== 1'b1 && t < 3) begin
            @(negedge clock);
            t++;
        end
        check("rd_valid", usb_rd_valid, 1'b1);
        check("rd_data", usb_rd_data & msk_q[i], exp_q[i] & msk_q[i]);
    endtask : usb_word

    // Optional rewind after the first word must resend from the frame start
    task automatic read_all(input bit rw);
        if (rw) begin
            usb_word(0);
            pulse(1'b1);
        end
        for (int i = 0; i < exp_q.size(); i++) usb_word(i);
        pulse(1'b0);
        exp_q.delete();
        msk_q.delete();
        repeat (3) @(posedge clock);
        check("avail_end", usb_frame_avail, 1'b0);
    endtask : read_all

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (80000) @(posedge clock);
        num_errors++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        @(negedge clock);
        check("idle_out", {usb_frame_avail, usb_block_ready, usb_rd_valid}, 3'h0);
        reg_check(8'h08, 32'h1);
        reg_check(8'h0c, 32'h0);
        reg_check(8'h04, 32'h0);
        reg_check(8'h20, 32'h0);
        for (int o = 0; o < 4; o++) begin
            set_cfg(o, 1'b0, 1'b1);
            send_frame(1 + lfsr_next() % 20, lfsr_next(), 1'b0);
            read_all(o == 2);
        end
        send_frame(9, 7'h7f, 1'b0);
        read_all(1'b0);
        set_cfg(0, 1'b0, 1'b0);
        send_frame(10, '0, 1'b0);
        send_frame(64, '0, 1'b0);
        read_all(1'b0);
        set_cfg(1, 1'b1, 1'b1);
        send_frame(70, 7'h02, 1'b0);
        send_frame(70, 7'h04, 1'b0);
        send_frame(70, 7'h20, 1'b0);
        read_all(1'b0);
        set_cfg(3, 1'b0, 1'b1);
        send_frame(1519, '0, 1'b0);
        read_all(1'b0);
        send_frame(2100, '0, 1'b1);
        reg_check(8'h04, 32'h1);
        send_frame(40, '0, 1'b0);
        read_all(1'b1);
        send_frame(30, '0, 1'b0);
        reg_write(8'h00, 32'h1b);
        exp_q.delete();
        msk_q.delete();
        repeat (3) @(posedge clock);
        check("flush_avail", usb_frame_avail, 1'b0);
        reg_check(8'h08, 32'h1);
        reg_check(8'h0c, 32'h0);
        send_frame(12, '0, 1'b0);
        read_all(1'b0);
        conclude();
    end
endmodule : rxff_ctrl_tb
